/* src/idac_pkg.sv */
// package: register map, field positions, reset values and types of the interpolating dac datapath
`default_nettype none
package idac_pkg;
  localparam logic [3:0] ADDR_CFG_LO = 4'h1;
  localparam logic [3:0] ADDR_CFG_HI = 4'h2;
  localparam logic [3:0] ADDR_FREQ0 = 4'h3;
  localparam logic [3:0] ADDR_PHASE0 = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h9;
  localparam logic [3:0] ADDR_OFFA_LO = 4'hA;
  localparam logic [3:0] ADDR_GOA_HI = 4'hB;
  localparam logic [3:0] ADDR_GAINA_LO = 4'hC;
  localparam logic [3:0] ADDR_OFFB_LO = 4'hD;
  localparam logic [3:0] ADDR_GOB_HI = 4'hE;
  localparam logic [3:0] ADDR_GAINB_LO = 4'hF;
  // cfg_lo fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int SEL_HI = 5;
  localparam int SEL_LO = 4;
  localparam int FBYPASS_BIT = 3;
  localparam int ISINC_BIT = 2;
  // cfg_hi fields
  localparam int NCO_BIT = 7;
  localparam int SSB_BIT = 6;
  localparam int RSPECT_BIT = 5;
  localparam int PHSYNC_BIT = 4;
  localparam int EXTCLK_BIT = 3;
  localparam logic [7:0] CFG_LO_RST = 8'h00;
  localparam logic [7:0] CFG_HI_RST = 8'h00;
  localparam logic [7:0] GAIN_LO_RST = 8'hFF;
  localparam logic [7:0] GO_HI_RST = 8'hF0;
  // mixer scale: sine table is q1.14
  localparam int TRIG_FRAC = 14;
  localparam int CLK_MHZ = 25;
  localparam int NCO_MAX_MHZ = 320;
  typedef enum logic [1:0] {
    IDAC_DUAL = 2'b00,
    IDAC_SSB = 2'b01,
    IDAC_QUAD = 2'b10,
    IDAC_RSVD = 2'b11
  } idac_mode_t;
  typedef struct packed {
    logic signed [15:0] a;
    logic signed [15:0] b;
  } idac_pair_t;
endpackage : idac_pkg
`default_nettype wire

/* src/idac_top.sv */
// interpolating dual dac digital datapath: capture, interpolation, nco mixer, gain and offset
//
// Functional notes
// - mode 00: two independent channels, each interpolated to its own converter.
// - each channel: four cascaded half-band stages then optional inverse-sinc filter.
// - two-bit select picks overall interpolation 2x, 4x, 8x or 16x.
// - filter-bypass routes samples around all interpolation stages.
// - mode 01: inputs are I/Q, mixed into a Hilbert pair on A and B.
// - A = I cos - Q sin, B = I sin + Q cos.
// - 32-bit tuning word loaded through four byte registers.
// - 16-bit phase offset from two byte registers added to oscillator phase.
// - oscillator accumulator advances once per update-rate sample.
// - oscillator off in ssb/quad: quarter-rate mix with 1 0 -1 0, accumulator frozen.
// - sideband bit negates the B mixer result in mode 01 and puts the A result on B in mode 10.
// - spectrum-reverse bit negates the sine term in the mixer.
// - gain and offset for both converters live at 0x0A to 0x0F.
// - each gain code sets its own converter full-scale current.
// - each offset code is added to its sample stream before conversion.
// - half-rate oscillator in ssb mode turns last filter into high-pass.
// - update clock must stay at or below 320 MHz with oscillator on.
// - pll and dual-clock modes capture words on primary clock rising edge.
// - external clock mode emits data-rate strobe; source aligns words to it.
// - mode 10: only converter B carries mixer output, A held constant.
// - with oscillator on, phase strobe high with async reset option clears accumulator until low.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`default_nettype none
module idac_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire idac_pkg::idac_pair_t data_in,
  input wire logic phase_strobe,
  output logic lock_strobe_output,
  output idac_pkg::idac_pair_t dac_out,
  output logic [11:0] gain_a,
  output logic [11:0] gain_b
);
  // update rate equals clk; oscillator limit only matters at the real rate
  localparam bit NCO_RATE_OK = idac_pkg::CLK_MHZ <= idac_pkg::NCO_MAX_MHZ;

  logic [7:0] regs_ff [16];
  logic [7:0] reg_rdata_ff;
  logic [31:0] acc_ff;
  logic [3:0] cnt_ff;
  logic [2:0] phs_sync_ff;
  logic lock_ff;
  idac_pkg::idac_pair_t cap_ff;
  idac_pkg::idac_pair_t mix_ff;
  idac_pkg::idac_pair_t dac_ff;
  idac_pkg::idac_pair_t sinc_d1_ff;
  idac_pkg::idac_pair_t sinc_d2_ff;

  // decoded controls
  idac_pkg::idac_mode_t mode;
  logic [1:0] sel;
  logic [2:0] n_stages;
  logic fbypass;
  logic isinc_en;
  logic nco_en;
  logic ssb;
  logic rspect;
  logic phs_async;
  logic ext_clk;
  logic [31:0] freq;
  logic [15:0] phase;
  logic signed [15:0] off_a;
  logic signed [15:0] off_b;

  assign mode = idac_pkg::idac_mode_t'(regs_ff[idac_pkg::ADDR_CFG_LO][idac_pkg::MODE_HI:idac_pkg::MODE_LO]);
  assign sel = regs_ff[idac_pkg::ADDR_CFG_LO][idac_pkg::SEL_HI:idac_pkg::SEL_LO];
  assign n_stages = {1'b0, sel} + 3'h1; // 00 -> 2x ... 11 -> 16x
  assign fbypass = regs_ff[idac_pkg::ADDR_CFG_LO][idac_pkg::FBYPASS_BIT];
  assign isinc_en = regs_ff[idac_pkg::ADDR_CFG_LO][idac_pkg::ISINC_BIT];
  assign nco_en = regs_ff[idac_pkg::ADDR_CFG_HI][idac_pkg::NCO_BIT];
  assign ssb = regs_ff[idac_pkg::ADDR_CFG_HI][idac_pkg::SSB_BIT];
  assign rspect = regs_ff[idac_pkg::ADDR_CFG_HI][idac_pkg::RSPECT_BIT];
  assign phs_async = ~regs_ff[idac_pkg::ADDR_CFG_HI][idac_pkg::PHSYNC_BIT];
  assign ext_clk = regs_ff[idac_pkg::ADDR_CFG_HI][idac_pkg::EXTCLK_BIT];
  // tuning word and phase, lowest address holds the low byte
  assign freq = {regs_ff[4'h6], regs_ff[4'h5], regs_ff[4'h4], regs_ff[idac_pkg::ADDR_FREQ0]};
  assign phase = {regs_ff[4'h8], regs_ff[idac_pkg::ADDR_PHASE0]};
  // 11-bit offsets sign-extended to sample width
  assign off_a = 16'(signed'({regs_ff[idac_pkg::ADDR_GOA_HI][2:0], regs_ff[idac_pkg::ADDR_OFFA_LO]}));
  assign off_b = 16'(signed'({regs_ff[idac_pkg::ADDR_GOB_HI][2:0], regs_ff[idac_pkg::ADDR_OFFB_LO]}));

  function automatic logic [3:0] lo_mask(input logic [2:0] bits);
    lo_mask = ~(4'hF << bits);
  endfunction : lo_mask

  function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh07FFF) begin
      sat16 = 16'h7FFF;
    end else if (v < -18'sh08000) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  // 16-point sine, q1.14; index is the top four phase bits
  function automatic logic signed [15:0] sin16(input logic [3:0] idx);
    logic [15:0] mag;
    logic [1:0] k;
    mag = 16'h0000;
    k = idx[2] ? 2'(4 - idx[1:0]) : idx[1:0];
    case ({idx[2] & (idx[1:0] == 2'b00), k})
      3'b000: mag = 16'h0000;
      3'b001: mag = 16'h187E;
      3'b010: mag = 16'h2D41;
      3'b011: mag = 16'h3B21;
      default: mag = 16'h4000;
    endcase
    sin16 = idx[3] ? -signed'(mag) : signed'(mag);
  endfunction : sin16

  // register file: byte-wide, writes land on the following edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 16; i++) begin
        regs_ff[i] <= 8'h00;
      end
      regs_ff[idac_pkg::ADDR_CFG_LO] <= idac_pkg::CFG_LO_RST;
      regs_ff[idac_pkg::ADDR_CFG_HI] <= idac_pkg::CFG_HI_RST;
      regs_ff[idac_pkg::ADDR_GAINA_LO] <= idac_pkg::GAIN_LO_RST;
      regs_ff[idac_pkg::ADDR_GAINB_LO] <= idac_pkg::GAIN_LO_RST;
      regs_ff[idac_pkg::ADDR_GOA_HI] <= idac_pkg::GO_HI_RST;
      regs_ff[idac_pkg::ADDR_GOB_HI] <= idac_pkg::GO_HI_RST;
    end else if (reg_wr && reg_addr != 4'h0 && reg_addr != idac_pkg::ADDR_STATUS) begin
      regs_ff[reg_addr] <= reg_wdata;
    end
  end

  // read port; status shows the accumulator top byte, unmapped 0x0 reads zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == idac_pkg::ADDR_STATUS) begin
        reg_rdata_ff <= acc_ff[31:24];
      end else if (reg_addr == 4'h0) begin
        reg_rdata_ff <= 8'h00;
      end else begin
        reg_rdata_ff <= regs_ff[reg_addr];
      end
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  // gain codes steer the converter current cells directly, no digital scaling
  assign gain_a = {regs_ff[idac_pkg::ADDR_GOA_HI][7:4], regs_ff[idac_pkg::ADDR_GAINA_LO]};
  assign gain_b = {regs_ff[idac_pkg::ADDR_GOB_HI][7:4], regs_ff[idac_pkg::ADDR_GAINB_LO]};

  // update-rate phase counter; data rate is the wrap of its low n_stages bits
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  logic data_en;
  assign data_en = (cnt_ff & lo_mask(n_stages)) == 4'h0;

  // capture on the data-rate edge; in external mode the strobe is the alignment mark
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cap_ff <= '0;
      lock_ff <= 1'b0;
    end else begin
      if (data_en) begin
        cap_ff <= data_in;
      end
      lock_ff <= ext_clk ? data_en : 1'b1;
    end
  end

  // half-band stages: linear interpolation keeps area small at some stop-band cost
  idac_pkg::idac_pair_t st_out [4];
  generate
    for (genvar g = 0; g < 4; g++) begin : g_stage
      idac_pkg::idac_pair_t cur_ff;
      idac_pkg::idac_pair_t prv_ff;
      idac_pkg::idac_pair_t out_ff;
      idac_pkg::idac_pair_t st_in;
      logic active;
      logic in_en;
      logic out_en;
      assign st_in = (g == 0) ? cap_ff : st_out[(g == 0) ? 0 : g - 1];
      assign active = 3'(g) < n_stages;
      assign in_en = (cnt_ff & lo_mask(3'(n_stages - 3'(g)))) == 4'h0;
      assign out_en = (cnt_ff & lo_mask(3'(n_stages - 3'(g) - 3'h1))) == 4'h0;
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          cur_ff <= '0;
          prv_ff <= '0;
          out_ff <= '0;
        end else if (active) begin
          if (in_en) begin
            prv_ff <= cur_ff;
            cur_ff <= st_in;
          end
          if (out_en) begin
            if (in_en) begin
              out_ff <= cur_ff;
            end else begin
              out_ff.a <= 16'((17'(cur_ff.a) + 17'(prv_ff.a)) >>> 1);
              out_ff.b <= 16'((17'(cur_ff.b) + 17'(prv_ff.b)) >>> 1);
            end
          end
        end
      end
      assign st_out[g] = active ? out_ff : st_in;
    end
  endgenerate

  idac_pkg::idac_pair_t filt;
  assign filt = fbypass ? cap_ff : st_out[3];

  // inverse sinc: 3-tap high-frequency boost, centre tap plus (2x1 - x0 - x2)/16
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sinc_d1_ff <= '0;
      sinc_d2_ff <= '0;
    end else begin
      sinc_d1_ff <= filt;
      sinc_d2_ff <= sinc_d1_ff;
    end
  end

  idac_pkg::idac_pair_t sinc_out;
  idac_pkg::idac_pair_t iq;
  assign sinc_out.a = sat16(18'(sinc_d1_ff.a) +
    ((18'(sinc_d1_ff.a) * 18'sd2 - 18'(filt.a) - 18'(sinc_d2_ff.a)) >>> 4));
  assign sinc_out.b = sat16(18'(sinc_d1_ff.b) +
    ((18'(sinc_d1_ff.b) * 18'sd2 - 18'(filt.b) - 18'(sinc_d2_ff.b)) >>> 4));
  assign iq = isinc_en ? sinc_out : sinc_d1_ff;

  // oscillator accumulator; frozen when the oscillator is powered down
  logic mixing;
  assign mixing = mode == idac_pkg::IDAC_SSB || mode == idac_pkg::IDAC_QUAD;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phs_sync_ff <= 3'b000;
    end else begin
      phs_sync_ff <= {phs_sync_ff[1:0], phase_strobe};
    end
  end

  // level moves only when the last two stages agree, so a strobe edge is never half-seen
  logic phs_high_ff;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phs_high_ff <= 1'b0;
    end else if (phs_sync_ff[2] == phs_sync_ff[1]) begin
      phs_high_ff <= phs_sync_ff[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc_ff <= 32'h0000_0000;
    end else if (nco_en && phs_async && phs_high_ff) begin
      acc_ff <= 32'h0000_0000;
    end else if (nco_en) begin
      acc_ff <= acc_ff + freq;
    end
  end

  // phase index: oscillator top bits, or quarter-rate walk through the same table
  logic [15:0] ph_word;
  logic [3:0] ph_idx;
  logic signed [15:0] sin_v;
  logic signed [15:0] cos_v;
  assign ph_word = acc_ff[31:16] + phase;
  assign ph_idx = nco_en ? ph_word[15:12] : {cnt_ff[1:0], 2'b00};
  assign sin_v = rspect ? -sin16(ph_idx) : sin16(ph_idx);
  assign cos_v = sin16(4'(ph_idx + 4'h4));

  // complex mix; half-rate tuning gives (-1)^n, a high-pass on the last stage
  logic signed [32:0] prod_a;
  logic signed [32:0] prod_b;
  logic signed [15:0] raw_a;
  logic signed [15:0] raw_b;
  assign prod_a = 33'(iq.a * cos_v) - 33'(iq.b * sin_v);
  assign prod_b = 33'(iq.a * sin_v) + 33'(iq.b * cos_v);
  assign raw_a = sat16(18'(prod_a >>> idac_pkg::TRIG_FRAC));
  assign raw_b = sat16(18'(prod_b >>> idac_pkg::TRIG_FRAC));

  // mode 11 falls back to the dual path; nothing relies on it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mix_ff <= '0;
    end else begin
      case (mode)
        idac_pkg::IDAC_SSB: begin
          mix_ff.a <= raw_a;
          mix_ff.b <= ssb ? sat16(-18'(raw_b)) : raw_b;
        end
        idac_pkg::IDAC_QUAD: begin
          mix_ff.a <= 16'h0000;
          mix_ff.b <= ssb ? raw_a : raw_b;
        end
        idac_pkg::IDAC_DUAL: begin
          mix_ff <= iq;
        end
        default: begin
          mix_ff <= iq;
        end
      endcase
    end
  end

  // offset added last; source must leave headroom or the result clips
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dac_ff <= '0;
    end else begin
      dac_ff.a <= sat16(18'(mix_ff.a) + 18'(off_a));
      dac_ff.b <= sat16(18'(mix_ff.b) + 18'(off_b));
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign lock_strobe_output = lock_ff;
  assign dac_out = dac_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence strobe_held;
    nco_en && phs_async && phs_high_ff;
  endsequence

  acc_clear_a: assert property (strobe_held |=> acc_ff == 32'h0)
    else $error("accumulator not cleared by phase strobe");
  nco_step_a: assert property (nco_en && !(phs_async && phs_high_ff) && $stable(freq)
    |=> acc_ff == $past(acc_ff) + $past(freq))
    else $error("accumulator did not advance by tuning word");
  nco_off_a: assert property (!nco_en |=> $stable(acc_ff))
    else $error("accumulator moved while oscillator off");
  quad_hold_a: assert property ((mode == idac_pkg::IDAC_QUAD && $stable(off_a)) [*3] |=> $stable(dac_ff.a))
    else $error("converter a not constant in quadrature mode");
  rate_a: assert property (ext_clk && $past(ext_clk) && lock_ff |-> $past(data_en))
    else $error("strobe not on data-rate edge");
  capture_a: assert property (data_en |=> cap_ff == $past(data_in))
    else $error("input word not captured");
  bypass_a: assert property (fbypass ##1 fbypass |-> sinc_d1_ff == $past(cap_ff))
    else $error("bypass did not skip interpolation");
  sideband_a: assert property (mode == idac_pkg::IDAC_SSB && ssb && raw_b != 16'h8000
    |=> mix_ff.b == -$past(raw_b))
    else $error("lower sideband not negated");
  offset_a: assert property (mix_ff.b == 16'h0000 |=> dac_ff.b == $past(off_b))
    else $error("offset not added to converter b");
  fs4_a: assert property (mixing && !nco_en && !rspect && cnt_ff[1:0] == 2'b00
    |-> cos_v == 16'sh4000 && sin_v == 16'sh0000)
    else $error("quarter-rate sequence wrong");
  rate_ok_a: assert property (NCO_RATE_OK)
    else $error("update clock above oscillator limit");
endmodule : idac_top
`default_nettype wire

/* tb/idac_src.sv */
// partner model: baseband sample source that feeds the dac datapath
`default_nettype none
module idac_src (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic lock_strobe_output,
  input wire logic signed [15:0] i_cmd,
  input wire logic signed [15:0] q_cmd,
  output idac_pkg::idac_pair_t data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic signed [15:0] AMP_MAX = 16'sh7000;

  // headroom kept for the largest offset so that adding it never clips on a sample that inverse sinc or the running oscillator has not raised
  function automatic logic signed [15:0] idac_clip(input logic signed [15:0] v);
    return (v > AMP_MAX) ? AMP_MAX : ((v < -AMP_MAX) ? -AMP_MAX : v);
  endfunction : idac_clip

  // a new word is launched just after a strobe edge, so it is stable across the capture
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      data_in <= '0;
    end else if (lock_strobe_output) begin
      data_in <= {idac_clip(i_cmd), idac_clip(q_cmd)};
    end
  end
endmodule : idac_src
`default_nettype wire

/* tb/test_interpolating_dac_datapath.sv */
// testbench: registers, mixer modes, gain and offset, nco and strobes of the dac datapath
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_interpolating_dac_datapath;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic signed [15:0] I_V = 16'sh0100;
  localparam logic signed [15:0] Q_V = 16'sh0040;
  typedef struct packed {logic [7:0] lo; logic [7:0] hi; logic [3:0] m;} idac_row_t;
  logic clk, rst_b, reg_wr, reg_rd, phase_strobe, lock_strobe_output;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d0, d1;
  logic [11:0] gain_a, gain_b;
  logic [3:0] seen;
  idac_pkg::idac_pair_t data_in, dac_out, ex;
  int n_errors, compares, np;
  // cfg_lo, cfg_hi, set of distinct output pairs expected over a quarter-rate period
  idac_row_t rows [10] = '{
    '{8'h00, 8'h00, 4'h1}, // dual, 2x
    '{8'h24, 8'h00, 4'h1}, // dual, 8x, inverse sinc on
    '{8'h30, 8'h00, 4'h1}, // dual, 16x
    '{8'h28, 8'h00, 4'h1}, // dual, filters bypassed
    '{8'h40, 8'h00, 4'hF}, // single sideband, quarter-rate mix
    '{8'h40, 8'h40, 4'hF}, // lower sideband
    '{8'h40, 8'h20, 4'hF}, // reversed spectrum
    '{8'h40, 8'h60, 4'hF}, // both options
    '{8'h80, 8'h00, 4'hF}, // quadrature
    '{8'h80, 8'h40, 4'hF}  // quadrature, other mixer output
  };

  // update clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  idac_top u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_in(data_in), .phase_strobe(phase_strobe),
    .lock_strobe_output(lock_strobe_output), .dac_out(dac_out), .gain_a(gain_a), .gain_b(gain_b));

  idac_src u_src (.clk(clk), .rst_b(rst_b), .lock_strobe_output(lock_strobe_output), .i_cmd(I_V),
    .q_cmd(Q_V), .data_in(data_in));

  // expected mixer pair for quarter-rate step k: cos 1 0 -1 0, sin 0 1 0 -1
  function automatic idac_pkg::idac_pair_t exp_pair(input logic [7:0] lo, input logic [7:0] hi, input int k);
    logic signed [15:0] c, s, a, b;
    c = (k == 0) ? 16'sh0001 : ((k == 2) ? -16'sh0001 : 16'sh0000);
    s = (k == 1) ? 16'sh0001 : ((k == 3) ? -16'sh0001 : 16'sh0000);
    if (hi[idac_pkg::RSPECT_BIT]) s = -s;
    a = I_V * c - Q_V * s;
    b = I_V * s + Q_V * c;
    if (lo[7:6] == 2'b10) return {16'h0000, hi[idac_pkg::SSB_BIT] ? a : b};
    if (lo[7:6] == 2'b01) return {a, hi[idac_pkg::SSB_BIT] ? -b : b};
    return {I_V, Q_V};
  endfunction : exp_pair

  // bus cycles: strobes raised and dropped at rising edges, read data taken the cycle after
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // strobe passes four flops (three synchroniser stages and the level flop) before it acts, so wait well past that
  task automatic clear_acc;
    @(posedge clk);
    phase_strobe <= 1'b1;
    cyc(8);
    rd(idac_pkg::ADDR_STATUS, d0);
    cyc(6);
    rd(idac_pkg::ADDR_STATUS, d1);
    `CHK({d0, d1}, 16'h0000)
    @(posedge clk);
    phase_strobe <= 1'b0;
    // the release crosses the synchroniser too; let the clear end before anyone counts steps
    cyc(4);
  endtask : clear_acc

  task automatic end_sim;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // watchdog: the sequence needs about 4550 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  // main sequence
  initial begin
    {rst_b, reg_wr, reg_rd, phase_strobe, reg_addr, reg_wdata} = '0;
    n_errors = 0;
    compares = 0;
    @(posedge clk);
    #1;
    `CHK({dac_out, lock_strobe_output}, 33'h0)
    @(posedge clk);
    rst_b <= 1'b1;
    rd(idac_pkg::ADDR_GAINA_LO, d0);
    rd(idac_pkg::ADDR_GOB_HI, d1);
    `CHK({d0, d1, gain_a, gain_b}, {idac_pkg::GAIN_LO_RST, idac_pkg::GO_HI_RST, 24'hFFFFFF})
    `CHK(lock_strobe_output, 1'b1)
    // unmapped place and a read that stands one cycle only
    wr(4'h0, 8'h55);
    rd(4'h0, d0);
    `CHK(d0, 8'h00)
    wr(idac_pkg::ADDR_CFG_LO, 8'h30);
    rd(idac_pkg::ADDR_CFG_LO, d0);
    cyc(1);
    `CHK({d0, reg_rdata}, 16'h3000)
    // table of modes: every sample must be one expected pair, all pairs seen
    foreach (rows[r]) begin
      wr(idac_pkg::ADDR_CFG_LO, rows[r].lo);
      wr(idac_pkg::ADDR_CFG_HI, rows[r].hi);
      cyc(300);
      seen = 4'h0;
      repeat (8) begin
        cyc(1);
        np = 4;
        for (int k = 3; k >= 0; k--)
          if (dac_out === exp_pair(rows[r].lo, rows[r].hi, k)) np = k;
        `CHK(np < 4, 1'b1)
        if (np < 4) seen[np] = 1'b1;
      end
      `CHK(seen, rows[r].m)
    end
    // gain and offset per converter, offset b negative
    wr(idac_pkg::ADDR_CFG_LO, 8'h00);
    wr(idac_pkg::ADDR_CFG_HI, 8'h00);
    wr(idac_pkg::ADDR_OFFA_LO, 8'h10);
    wr(idac_pkg::ADDR_GOA_HI, 8'h50);
    wr(idac_pkg::ADDR_GAINA_LO, 8'h23);
    wr(idac_pkg::ADDR_OFFB_LO, 8'hF0);
    wr(idac_pkg::ADDR_GOB_HI, 8'hA7);
    wr(idac_pkg::ADDR_GAINB_LO, 8'h45);
    rd(idac_pkg::ADDR_GOA_HI, d0);
    `CHK({d0, gain_a, gain_b}, {8'h50, 12'h523, 12'hA45})
    cyc(300);
    `CHK(dac_out, {I_V + 16'sh0010, Q_V - 16'sh0010})
    // external clock mode at 4x: one strobe pulse every 4 cycles, data still captured
    wr(idac_pkg::ADDR_CFG_LO, 8'h10);
    wr(idac_pkg::ADDR_CFG_HI, 8'h08);
    cyc(300);
    np = 0;
    repeat (64) begin
      cyc(1);
      if (lock_strobe_output === 1'b1) np++;
    end
    `CHK(np, 16)
    `CHK(dac_out, {I_V + 16'sh0010, Q_V - 16'sh0010})
    // nco: tuning word 0x02800000 adds 25 to the top byte in ten cycles
    wr(idac_pkg::ADDR_CFG_LO, 8'h40);
    wr(4'h6, 8'h02);
    wr(4'h5, 8'h80);
    wr(4'h4, 8'h00);
    wr(idac_pkg::ADDR_FREQ0, 8'h00);
    wr(idac_pkg::ADDR_CFG_HI, 8'h80);
    clear_acc();
    rd(idac_pkg::ADDR_STATUS, d0);
    cyc(8);
    rd(idac_pkg::ADDR_STATUS, d1);
    `CHK(d1 - d0, 8'h19)
    wr(idac_pkg::ADDR_CFG_HI, 8'h00);
    rd(idac_pkg::ADDR_STATUS, d0);
    cyc(8);
    rd(idac_pkg::ADDR_STATUS, d1);
    `CHK(d1 - d0, 8'h00)
    // quarter-turn phase offset with a still oscillator: a = -q, b = i
    wr(4'h6, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h8, 8'h40);
    wr(idac_pkg::ADDR_CFG_HI, 8'h80);
    clear_acc();
    cyc(300);
    `CHK(dac_out, {-Q_V + 16'sh0010, I_V - 16'sh0010})
    // half-rate oscillator: outputs flip sign every sample
    wr(4'h8, 8'h00);
    wr(4'h6, 8'h80);
    clear_acc();
    cyc(300);
    ex = dac_out;
    cyc(1);
    `CHK({ex.a + dac_out.a, ex.b + dac_out.b}, {16'sh0020, -16'sh0020})
    `CHK((ex.a == I_V + 16'sh0010) || (ex.a == -I_V + 16'sh0010), 1'b1)
    // mid-run reset returns registers and outputs to their idle values
    @(posedge clk);
    rst_b <= 1'b0;
    cyc(2);
    `CHK({dac_out, gain_a, gain_b, lock_strobe_output}, {32'h0, 24'hFFFFFF, 1'b0})
    @(posedge clk);
    rst_b <= 1'b1;
    rd(idac_pkg::ADDR_CFG_LO, d0);
    `CHK({d0, lock_strobe_output}, {idac_pkg::CFG_LO_RST, 1'b1})
    end_sim();
  end
endmodule : test_interpolating_dac_datapath
`default_nettype wire
